// File: src/ipt_internal_position_trigger.sv
`timescale 1ns/1ps
`default_nettype none
`include "ipt_map.svh"
module ipt_internal_position_trigger #(
  parameter int TICK_CYCLES = `IPT_TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // input terminals
  input wire logic storedMoveTrigger,
  input wire logic moveSelectBit0,
  input wire logic moveSelectBit1,
  input wire logic moveSelectBit2,
  input wire logic moveStop,
  input wire logic jogForwardInput,
  input wire logic jogReverseInput,
  // drive state
  output logic zeroSpeedFlag,
  output logic moveActive,
  output var ipt_pkg::ipt_speed_t motorSpeed,
  output var ipt_pkg::ipt_pos_t motorPosition
);
  import ipt_pkg::*;

  localparam int NE = `IPT_NUM_ENTRIES;

  logic [2:0] controlModeParam_ff;
  logic [2:0] speedSourceParam_ff;
  ipt_mag_t jogSpeedParam_ff;
  ipt_mag_t zeroSpeedThresholdParam_ff;
  ipt_pos_t entryDist_ff [NE];
  ipt_mag_t entrySpeed_ff [NE];
  ipt_state_t state_ff;
  logic [31:0] remaining_ff;
  ipt_mag_t step_ff;
  logic dirNeg_ff;
  logic [1:0] activeEntry_ff;
  logic trigPrev_ff;
  logic tick;

  logic [2:0] selCode;
  logic trigRise;
  logic intPosMode;
  logic holdActive;
  logic startMove;
  logic abortMove;
  logic jogMode;
  ipt_speed_t jogSpeedNext;
  ipt_speed_t absSpeed;
  ipt_pos_t stepSigned;
  logic [31:0] startDist;
  ipt_pos_t selDist;
  ipt_mag_t selSpeed;

  ipt_tick_div #(
    .DIV(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .rst(rst),
    .tick(tick)
  );

  // apb access
  logic apbAccess;
  logic apbCommit;
  logic rdHit;
  logic [31:0] rdVal;
  logic entryHit;
  logic [1:0] entryIdx;

  assign apbAccess = psel & penable & ~pready;
  assign apbCommit = psel & penable & pready;
  assign entryIdx = paddr[4:3];
  assign entryHit = (paddr[7:5] == `IPT_OFS_ENTRY_BASE) && (paddr[1:0] == 2'h0);

  always_comb begin
    rdHit = 1'b1;
    rdVal = 32'h0000_0000;
    if (entryHit) begin
      rdVal = paddr[2] ? {17'h0_0000, entrySpeed_ff[entryIdx]} : entryDist_ff[entryIdx];
    end else begin
      case (paddr)
        `IPT_OFS_CTRL: rdVal = {25'h000_0000, speedSourceParam_ff, 1'b0, controlModeParam_ff};
        `IPT_OFS_JOG: rdVal = {17'h0_0000, jogSpeedParam_ff};
        `IPT_OFS_ZSTHR: rdVal = {17'h0_0000, zeroSpeedThresholdParam_ff};
        `IPT_OFS_STATUS: rdVal = {25'h000_0000, 1'b0, activeEntry_ff, 1'b0,
                                  holdActive, moveActive, zeroSpeedFlag};
        `IPT_OFS_POS: rdVal = motorPosition;
        `IPT_OFS_SPEED: rdVal = {{16{motorSpeed[15]}}, motorSpeed};
        default: rdHit = 1'b0;
      endcase
    end
  end

  // one wait state so read data is registered on the same edge as pready
  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apbAccess;
      prdata <= (apbAccess && !pwrite && rdHit) ? rdVal : 32'h0000_0000;
      pslverr <= apbAccess & ~rdHit;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      controlModeParam_ff <= `IPT_RST_MODE;
      speedSourceParam_ff <= `IPT_RST_SRC;
      jogSpeedParam_ff <= `IPT_RST_JOG;
      zeroSpeedThresholdParam_ff <= `IPT_RST_ZSTHR;
      for (int i = 0; i < NE; i++) begin
        entryDist_ff[i] <= 32'h0000_0000;
        entrySpeed_ff[i] <= 15'h0000;
      end
    end else if (apbCommit && pwrite) begin
      if (entryHit) begin
        if (paddr[2]) begin
          entrySpeed_ff[entryIdx] <= pwdata[14:0];
        end else begin
          entryDist_ff[entryIdx] <= pwdata;
        end
      end else begin
        case (paddr)
          `IPT_OFS_CTRL: begin
            controlModeParam_ff <= pwdata[`IPT_CTRL_MODE_LSB +: 3];
            speedSourceParam_ff <= pwdata[`IPT_CTRL_SRC_LSB +: 3];
          end
          `IPT_OFS_JOG: jogSpeedParam_ff <= pwdata[14:0];
          `IPT_OFS_ZSTHR: zeroSpeedThresholdParam_ff <= pwdata[14:0];
          default: ;
        endcase
      end
    end
  end

  // terminal decode
  assign selCode = {moveSelectBit2, moveSelectBit1, moveSelectBit0};
  // a held trigger counts once: only its rising step starts a move
  assign trigRise = storedMoveTrigger & ~trigPrev_ff;
  assign intPosMode = (controlModeParam_ff == `IPT_MODE_INTPOS);
  assign holdActive = intPosMode & moveStop;
  // codes 100..111 belong to the upper entries, not handled here
  assign startMove = trigRise & intPosMode & ~holdActive & zeroSpeedFlag & ~selCode[2];
  // a move cut by a mode change is dropped, not resumed later
  assign abortMove = holdActive | ((state_ff == IPT_MOVING) & ~intPosMode);
  assign jogMode = (controlModeParam_ff == `IPT_MODE_SPEED)
                 && (speedSourceParam_ff == `IPT_SRC_JOG);
  assign selDist = entryDist_ff[selCode[1:0]];
  assign selSpeed = entrySpeed_ff[selCode[1:0]];
  assign startDist = selDist[31] ? 32'(-selDist) : selDist;
  assign stepSigned = dirNeg_ff ? -$signed({17'h0_0000, step_ff})
                                : $signed({17'h0_0000, step_ff});

  // both jog inputs on cancel rather than pick a side
  always_comb begin
    jogSpeedNext = 16'h0000;
    if (jogForwardInput && !jogReverseInput) begin
      jogSpeedNext = $signed({1'b0, jogSpeedParam_ff});
    end else if (jogReverseInput && !jogForwardInput) begin
      jogSpeedNext = -$signed({1'b0, jogSpeedParam_ff});
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      trigPrev_ff <= 1'b0;
    end else begin
      trigPrev_ff <= storedMoveTrigger;
    end
  end

  // motion: stored moves advance one step per tick
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= IPT_IDLE;
      remaining_ff <= 32'h0000_0000;
      step_ff <= 15'h0000;
      dirNeg_ff <= 1'b0;
      activeEntry_ff <= 2'h0;
      motorSpeed <= 16'h0000;
      motorPosition <= 32'h0000_0000;
      moveActive <= 1'b0;
    end else if (abortMove) begin
      state_ff <= IPT_IDLE;
      remaining_ff <= 32'h0000_0000;
      motorSpeed <= 16'h0000;
      moveActive <= 1'b0;
    end else if (startMove) begin
      state_ff <= IPT_MOVING;
      remaining_ff <= startDist;
      step_ff <= selSpeed;
      dirNeg_ff <= selDist[31];
      activeEntry_ff <= selCode[1:0];
      motorSpeed <= selDist[31] ? -$signed({1'b0, selSpeed}) : $signed({1'b0, selSpeed});
      moveActive <= 1'b1;
    end else begin
      case (state_ff)
        IPT_MOVING: begin
          if (tick) begin
            // zero step speed would never finish, so it jumps to target
            if (remaining_ff <= {17'h0_0000, step_ff} || step_ff == 15'h0000) begin
              motorPosition <= dirNeg_ff ? motorPosition - $signed(remaining_ff)
                                         : motorPosition + $signed(remaining_ff);
              remaining_ff <= 32'h0000_0000;
              motorSpeed <= 16'h0000;
              state_ff <= IPT_IDLE;
              moveActive <= 1'b0;
            end else begin
              remaining_ff <= remaining_ff - {17'h0_0000, step_ff};
              motorPosition <= motorPosition + stepSigned;
            end
          end
        end
        IPT_IDLE: begin
          if (jogMode) begin
            motorSpeed <= jogSpeedNext;
            if (tick) begin
              motorPosition <= motorPosition + {{16{motorSpeed[15]}}, motorSpeed};
            end
          end else begin
            motorSpeed <= 16'h0000;
          end
        end
        default: state_ff <= IPT_IDLE;
      endcase
    end
  end

  // zero-speed output, one cycle behind speed
  assign absSpeed = motorSpeed[15] ? -motorSpeed : motorSpeed;

  always_ff @(posedge clk) begin
    if (rst) begin
      zeroSpeedFlag <= 1'b1;
    end else begin
      zeroSpeedFlag <= (absSpeed < $signed({1'b0, zeroSpeedThresholdParam_ff}));
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  a_stop_halts_motor: assert property (holdActive |=> motorSpeed == 16'h0000 && !moveActive)
    else $error("stop input did not halt the motor");
  a_stop_mode_gate: assert property (
    moveStop && jogMode && jogForwardInput && !jogReverseInput && !moveActive
    |=> motorSpeed == $signed({1'b0, $past(jogSpeedParam_ff)}))
    else $error("stop input acted outside internal position mode");
  a_trigger_starts_move: assert property (
    trigRise && intPosMode && !moveStop && zeroSpeedFlag && !selCode[2]
    |=> moveActive ##0 state_ff == IPT_MOVING)
    else $error("trigger at zero speed did not start a move");
  a_trigger_other_mode: assert property (
    trigRise && !intPosMode && !moveActive |=> !moveActive)
    else $error("trigger started a move outside internal position mode");
  a_select_picks_entry: assert property (
    startMove |=> {1'b0, activeEntry_ff} == $past(selCode))
    else $error("move started from the wrong entry");
  a_upper_code_ignored: assert property (
    trigRise && selCode[2] && !moveActive |=> !moveActive)
    else $error("upper select code started a move");
  // a tick may still advance the move in the cycle of the refused trigger
  a_busy_trigger_ignored: assert property (
    trigRise && !zeroSpeedFlag && moveActive && !abortMove
    |=> $stable(activeEntry_ff) && ($past(tick) || (moveActive && $stable(remaining_ff))))
    else $error("trigger accepted while motor still moving");
  // checked as a window around zero, not through the magnitude
  a_zero_speed_flag: assert property (
    1'b1 |=> zeroSpeedFlag ==
      ($past(motorSpeed) < $signed({1'b0, $past(zeroSpeedThresholdParam_ff)})
      && $past(motorSpeed) > -$signed({1'b0, $past(zeroSpeedThresholdParam_ff)})))
    else $error("zero speed flag disagrees with speed and threshold");
  a_jog_both_off: assert property (
    jogMode && jogForwardInput && jogReverseInput && !moveActive |=> motorSpeed == 16'h0000)
    else $error("jog with both inputs on moved the motor");
  a_jog_reverse: assert property (
    jogMode && jogReverseInput && !jogForwardInput && !moveActive
    |=> motorSpeed == -$signed({1'b0, $past(jogSpeedParam_ff)}))
    else $error("reverse jog speed wrong");
  a_apb_one_wait: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb answer not after one wait state");
  a_apb_err_unmapped: assert property (psel && penable && !pready && !rdHit |=> pslverr && pready)
    else $error("unmapped address answered without error");
  a_idle_position_hold: assert property (!jogMode && !moveActive |=> $stable(motorPosition))
    else $error("position moved with no stored move and no jog");
  a_mode_exit_abort: assert property (moveActive && !intPosMode |=> !moveActive)
    else $error("stored move kept running outside internal position mode");
  a_done_at_rest: assert property ($fell(moveActive) |-> motorSpeed == 16'h0000)
    else $error("move ended with the motor still turning");

  c_move_done: cover property (startMove ##[1:1000] $fell(moveActive));
  c_move_held: cover property (moveActive ##1 holdActive);
  c_trig_refused: cover property (trigRise && intPosMode && !zeroSpeedFlag);
  c_jog_fwd: cover property (jogMode && jogForwardInput && !jogReverseInput ##1 tick);
  c_upper_code: cover property (trigRise && intPosMode && selCode[2]);
endmodule : ipt_internal_position_trigger
`default_nettype wire

// File: src/ipt_map.svh
// Overview of operation
// - stop input halts motor, aborts stored move
// - stop acts only in internal position mode
// - trigger edge starts selected stored move
// - select bits binary-code the stored entry
// - new trigger accepted only at zero speed
// - zero speed when magnitude below threshold
`ifndef IPT_MAP_SVH
`define IPT_MAP_SVH

`define IPT_CLK_PERIOD_NS 20
`define IPT_TICK_NS 1000
`define IPT_TICK_CYCLES ((`IPT_TICK_NS + `IPT_CLK_PERIOD_NS - 1) / `IPT_CLK_PERIOD_NS)

`define IPT_NUM_ENTRIES 4

`define IPT_OFS_CTRL 8'h00
`define IPT_OFS_JOG 8'h04
`define IPT_OFS_ZSTHR 8'h08
`define IPT_OFS_STATUS 8'h0C
`define IPT_OFS_POS 8'h10
`define IPT_OFS_SPEED 8'h14
`define IPT_OFS_ENTRY_BASE 3'h1

`define IPT_CTRL_MODE_LSB 0
`define IPT_CTRL_SRC_LSB 4

`define IPT_MODE_SPEED 3'h1
`define IPT_MODE_INTPOS 3'h3
`define IPT_SRC_JOG 3'h5

`define IPT_RST_MODE 3'h0
`define IPT_RST_SRC 3'h0
`define IPT_RST_JOG 15'h0000
`define IPT_RST_ZSTHR 15'h000A

`endif

// File: src/ipt_pkg.sv
package ipt_pkg;
  typedef enum logic {
    IPT_IDLE,
    IPT_MOVING
  } ipt_state_t;
  typedef logic signed [15:0] ipt_speed_t;
  typedef logic [14:0] ipt_mag_t;
  typedef logic signed [31:0] ipt_pos_t;
endpackage : ipt_pkg

// File: src/ipt_tick_div.sv
`timescale 1ns/1ps
`default_nettype none
module ipt_tick_div #(
  parameter int DIV = 50
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // enable out
  output logic tick
);
  localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);
  logic [CW-1:0] cnt_ff;

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_ff <= '0;
      tick <= 1'b0;
    end else begin
      tick <= (cnt_ff == LAST);
      cnt_ff <= (cnt_ff == LAST) ? '0 : cnt_ff + 1'b1;
    end
  end
endmodule : ipt_tick_div
`default_nettype wire

// File: tb/ipt_ctrl_model.sv
`timescale 1ns/1ps
`default_nettype none
module ipt_ctrl_model (
  // clock
  input wire logic clk,
  // discrete terminals
  output logic trg,
  output logic [2:0] sel,
  output logic stop,
  output logic jogF,
  output logic jogR
);
  initial begin
    trg = 1'b0;
    sel = 3'h0;
    stop = 1'b0;
    jogF = 1'b0;
    jogR = 1'b0;
  end
  // code settles one edge before the edge, so the select is never caught mid-change
  task automatic fire(input logic [2:0] code);
    @(posedge clk);
    sel <= code;
    @(posedge clk);
    trg <= 1'b1;
    repeat (3) @(posedge clk);
    trg <= 1'b0;
  endtask : fire
  // stop is a level and stays as set until the next call
  task automatic hold(input logic level);
    @(posedge clk);
    stop <= level;
  endtask : hold
  task automatic jog(input logic fwd, input logic rev);
    @(posedge clk);
    jogF <= fwd;
    jogR <= rev;
  endtask : jog
endmodule : ipt_ctrl_model
`default_nettype wire

// File: tb/internal_position_trigger_tb.sv
`timescale 1ns/1ps
`default_nettype none
module internal_position_trigger_tb;
  import ipt_pkg::*;
  localparam int TICKS = 4;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err;
  logic zeroSpeedFlag, moveActive, trg, stop, jogF, jogR;
  logic [2:0] sel;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  ipt_speed_t motorSpeed;
  ipt_pos_t motorPosition, expPos, p0;
  int errors, checks;

  ipt_internal_position_trigger #(.TICK_CYCLES(TICKS)) uut (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .storedMoveTrigger(trg), .moveSelectBit0(sel[0]), .moveSelectBit1(sel[1]),
    .moveSelectBit2(sel[2]), .moveStop(stop), .jogForwardInput(jogF),
    .jogReverseInput(jogR), .zeroSpeedFlag(zeroSpeedFlag), .moveActive(moveActive),
    .motorSpeed(motorSpeed), .motorPosition(motorPosition));
  ipt_ctrl_model m (.clk(clk), .trg(trg), .sel(sel), .stop(stop), .jogF(jogF), .jogR(jogR));

  always #10 clk = ~clk;

  task automatic report_and_stop;
    $display("errors=%0d checks=%0d", errors, checks);
    if (errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      report_and_stop;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_idle;
    int n;
    n = 0;
    repeat (2) @(posedge clk);
    while ((moveActive !== 1'b0 || zeroSpeedFlag !== 1'b1) && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n >= 400) begin
      errors++;
      report_and_stop;
    end
  endtask : wait_idle

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    errors = 0;
    checks = 0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(rd, 32'h0000_000A);
    apb(1'b1, 8'h0C, 32'h0000_00FF);
    apb(1'b0, 8'h0C, 32'h0000_0000);
    chk(rd, 32'h0000_0001);
    apb(1'b0, 8'h18, 32'h0000_0000);
    chk({31'h0, err}, 32'h0000_0001);
    $display("test regs done");
    apb(1'b1, 8'h00, 32'h0000_0003);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, 8'(32 + 8 * i), 32'(30 * (i + 1)));
      apb(1'b1, 8'(36 + 8 * i), 32'h0000_0014);
    end
    expPos = 0;
    for (int i = 0; i < 4; i++) begin
      m.fire(3'(i));
      wait_idle;
      expPos = expPos + 30 * (i + 1);
      chk(motorPosition, expPos);
    end
    // codes 1xx belong to entries this block does not serve
    m.fire(3'h4);
    repeat (4) @(posedge clk);
    chk({31'h0, moveActive}, 32'h0000_0000);
    chk(motorPosition, expPos);
    $display("test select done");
    apb(1'b1, 8'h20, 32'h0000_00C8);
    m.fire(3'h0);
    chk({31'h0, zeroSpeedFlag}, 32'h0000_0000);
    // retrigger lands mid-move and must not change the target
    m.fire(3'h1);
    wait_idle;
    expPos = expPos + 200;
    chk(motorPosition, expPos);
    $display("test retrigger done");
    m.fire(3'h0);
    m.hold(1'b1);
    repeat (2) @(posedge clk);
    chk({31'h0, moveActive}, 32'h0000_0000);
    chk(motorSpeed, 32'h0000_0000);
    p0 = motorPosition;
    m.fire(3'h1);
    repeat (10) @(posedge clk);
    chk(motorPosition, p0);
    $display("test stop done");
    // leaving the stored-move mode mid-move drops the move
    m.hold(1'b0);
    m.fire(3'h0);
    apb(1'b1, 8'h00, 32'h0000_0051);
    repeat (2) @(posedge clk);
    chk({31'h0, moveActive}, 32'h0000_0000);
    // stop stays on through the jog steps: it must not act in speed mode
    m.hold(1'b1);
    apb(1'b1, 8'h04, 32'h0000_0007);
    m.jog(1'b1, 1'b0);
    repeat (3) @(posedge clk);
    chk(motorSpeed, 32'h0000_0007);
    chk({31'h0, zeroSpeedFlag}, 32'h0000_0001);
    apb(1'b1, 8'h04, 32'h0000_000A);
    repeat (3) @(posedge clk);
    chk({31'h0, zeroSpeedFlag}, 32'h0000_0000);
    m.jog(1'b1, 1'b1);
    repeat (3) @(posedge clk);
    chk(motorSpeed, 32'h0000_0000);
    m.jog(1'b0, 1'b1);
    repeat (3) @(posedge clk);
    apb(1'b0, 8'h14, 32'h0000_0000);
    chk(rd, 32'hFFFF_FFF6);
    $display("test jog done");
    report_and_stop;
  end
endmodule : internal_position_trigger_tb
`default_nettype wire
